/* File: common/psi_pkg.sv */
// Purpose: Shared constants and types of the port status indicator block
// Assumes: 10 MHz core clock, four ports
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package psi_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_PORTS = 4;           // Ports of the transceiver
  localparam int FIELDS_PER_PORT = 4;     // Bits per port in a serial frame
  localparam int FRAME_BITS = 16;         // Bits in one serial frame

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLK_HZ = 64'd10000000;      // Core clock rate
  localparam longint ACT_HOLD_MS = 64'd80;       // Activity pulse length
  localparam int ACT_HOLD_CYC =
    int'((ACT_HOLD_MS * CLK_HZ) / 64'd1000);     // Activity pulse cycles
  localparam int SER_DIV_CYC = 5;                // Core cycles per half bit

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;    // Pin mode control, RW
  localparam logic [3:0] REG_STATUS = 4'h4;  // Live state, RO
  localparam logic [3:0] REG_EVENT = 4'h8;   // Sticky events, W1C
  localparam logic [3:0] REG_MASK = 4'hc;    // Event mask, RW

  // Control fields
  localparam int CTRL_PORT_INTERRUPT_N_BIT = 0;          // interrupt_pin_mode
  localparam int CTRL_DUPLEX_BIT = 1;        // duplex_pin_mode

  // Status fields
  localparam int STAT_LINK_LSB = 0;          // Link state of each port
  localparam int STAT_SERIAL_BIT = 4;        // Serial mode latched
  localparam int STAT_LOWCOST_BIT = 5;       // Low-cost mode latched
  localparam int STAT_TXERR_BIT = 6;         // Transmit error pin mode

  // Event fields
  localparam int EVT_LINK_LSB = 0;           // Link changed, per port
  localparam int EVT_TXERR_LSB = 4;          // Transmit error seen, per port
  localparam int EVT_BITS = 8;               // Width of event and mask

  // Reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [NUM_PORTS-1:0] psi_port_t;  // One bit per port

  // Live status of one physical layer port
  typedef struct packed {
    logic link_good;     // Link pass state
    logic speed100;      // Runs at 100 Mb/s
    logic full_duplex;   // Full-duplex resolved
    logic tx_activity;   // Transmit activity seen this cycle
    logic rx_activity;   // Receive activity seen this cycle
  } psi_phy_s;

  // Pin levels of the indicator pins of all ports
  typedef struct packed {
    psi_port_t link_n;     // link_indicator_n pins
    psi_port_t speed_n;    // speed_indicator_n pins
    psi_port_t speed_oe_n; // Low while speed pins are driven
    psi_port_t xmt_n;      // transmit_activity_indicator_n pins
    psi_port_t rcv_n;      // receive_activity_indicator_n pins
  } psi_pins_s;

endpackage

/* File: logic/psi_activity_timer.sv */
// Purpose: Retriggerable pulse stretcher for one activity indicator
// Assumes: Synchronous active-low reset, one clock
// Notes: Cleared at once when allow drops
`timescale 1ns/1ps
module psi_activity_timer #(
  parameter int HOLD_CYCLES = 800000,
  parameter int CNT_W = $clog2(HOLD_CYCLES + 1)
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic trigger_in,   // Activity this cycle
  input wire logic allow_in,     // Link pass state
  // Result
  output logic active_out        // High while the pulse lasts
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Cycles left in the pulse
    logic active;            // Registered pulse level
  } psi_tmr_s;

  localparam logic [CNT_W-1:0] HOLD = CNT_W'(HOLD_CYCLES);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  psi_tmr_s st_r;
  psi_tmr_s st_nxt;

  // Next state of the pulse counter
  always_comb begin
    st_nxt = st_r;
    if (!rst_n_in) begin
      st_nxt = '0;
    end else if (!allow_in) begin
      st_nxt = '0;                       // Only in link pass
    end else if (trigger_in) begin
      st_nxt.cnt = HOLD;
      st_nxt.active = 1'b1;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - ONE;
      st_nxt.active = (st_r.cnt > ONE);
    end else begin
      st_nxt.active = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    st_r <= st_nxt;
  end

  assign active_out = st_r.active;

endmodule

/* File: logic/psi_indicator_top.sv */
// Purpose: Per-port status indicators with strap-selected pin functions
// Assumes: Straps stable while rst_n_in is low; inputs synchronous
// Notes: Registers over Avalon-MM, one wait cycle per access
//
// Behaviour
// - Link pin low while that port's link good
// - Serial mode chosen by strap low at reset
// - Serial mode: port 2 link pin is frame
// - Low-cost serial mode chosen by strap at reset
// - Speed pin low at 100, high at 10
// - Strap low: speed pins become transmit error inputs
// - Transmit pin low 80 ms after activity, link pass
// - Interrupt mode: transmit pin is port interrupt
// - Duplex mode: transmit pin shows full duplex
// - Serial mode: port 2 transmit pin is data
// - Receive pin low 80 ms after activity, link pass
// - Interrupt or duplex mode: receive pin shows any activity
// - Serial mode: port 2 receive pin is clock
// - Low-cost: port 1 clock, port 3 data
// - Straps sampled only at hardware reset
// - Select low makes speed pins inputs
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module psi_indicator_top #(
  parameter int ACT_HOLD_CYCLES = psi_pkg::ACT_HOLD_CYC,
  parameter int SER_DIV_CYCLES = psi_pkg::SER_DIV_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Straps, sampled while reset is low
  input wire logic serial_indicator_select_n_in,
  input wire logic lowcost_serial_indicator_select_n_in,
  input wire logic transmit_error_pin_select_n_in,
  // Port state from the transceiver core
  input wire psi_pkg::psi_phy_s [psi_pkg::NUM_PORTS-1:0] phy_in,
  // Speed pin input side, transmit_error_in when selected
  input wire psi_pkg::psi_port_t transmit_error_in,
  // Indicator pins
  output psi_pkg::psi_pins_s pins_out,
  // Transmit error towards the core
  output psi_pkg::psi_port_t transmit_error_out,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Interrupt
  output logic irq_out
);

  localparam int NP = psi_pkg::NUM_PORTS;
  localparam int FB = psi_pkg::FRAME_BITS;
  localparam int DIV_W = $clog2(SER_DIV_CYCLES + 1);
  localparam int IDX_W = $clog2(FB);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SER_DIV_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
  localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);

  ////////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    logic serial_mode;                  // Latched serial strap
    logic lowcost_mode;                 // Latched low-cost strap
    logic txerr_mode;                   // Latched transmit error strap
    logic [1:0] ctrl;                   // Pin mode control
    logic [psi_pkg::EVT_BITS-1:0] evt;  // Sticky events
    logic [psi_pkg::EVT_BITS-1:0] mask; // Event mask
    psi_pkg::psi_port_t link_prev;      // Link state one cycle ago
    logic wait_n;                       // High only in the answer cycle
    logic [31:0] rdata;                 // Read data
    logic [DIV_W-1:0] div;              // Serial clock divider
    logic sclk;                         // Serial clock level
    logic [IDX_W-1:0] idx;              // Bit index in the frame
    logic [FB-1:0] frame;               // Frame being shifted
    logic sdata;                        // Current serial bit
    psi_pkg::psi_pins_s pins;           // Pin levels
    psi_pkg::psi_port_t txerr;          // Transmit error to core
    logic irq;                          // Interrupt level
  } psi_state_s;

  psi_state_s st_r;
  psi_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Register read decode
  function automatic logic [31:0] read_word(
    input logic [3:0] addr,
    input psi_state_s s,
    input psi_pkg::psi_port_t link
  );
    logic [31:0] w;
    w = 32'h0;
    case (addr)
      psi_pkg::REG_CTRL: begin
        w[1:0] = s.ctrl;
      end
      psi_pkg::REG_STATUS: begin
        w[psi_pkg::STAT_LINK_LSB +: NP] = link;
        w[psi_pkg::STAT_SERIAL_BIT] = s.serial_mode;
        w[psi_pkg::STAT_LOWCOST_BIT] = s.lowcost_mode;
        w[psi_pkg::STAT_TXERR_BIT] = s.txerr_mode;
      end
      psi_pkg::REG_EVENT: begin
        w[psi_pkg::EVT_BITS-1:0] = s.evt;
      end
      psi_pkg::REG_MASK: begin
        w[psi_pkg::EVT_BITS-1:0] = s.mask;
      end
      default: begin
        w = 32'h0;                      // Unmapped reads as zero
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Activity pulse timers, transmit, receive and combined per port
  psi_pkg::psi_port_t tx_act;
  psi_pkg::psi_port_t rx_act;
  psi_pkg::psi_port_t any_act;
  psi_pkg::psi_port_t link_now;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      assign link_now[gp] = phy_in[gp].link_good;

      // Transmit pulse
      psi_activity_timer #(
        .HOLD_CYCLES(ACT_HOLD_CYCLES)
      ) u_tx (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .trigger_in(phy_in[gp].tx_activity),
        .allow_in(phy_in[gp].link_good),
        .active_out(tx_act[gp])
      );

      // Receive pulse
      psi_activity_timer #(
        .HOLD_CYCLES(ACT_HOLD_CYCLES)
      ) u_rx (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .trigger_in(phy_in[gp].rx_activity),
        .allow_in(phy_in[gp].link_good),
        .active_out(rx_act[gp])
      );

      // Combined pulse for either direction
      psi_activity_timer #(
        .HOLD_CYCLES(ACT_HOLD_CYCLES)
      ) u_any (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .trigger_in(phy_in[gp].rx_activity | phy_in[gp].tx_activity),
        .allow_in(phy_in[gp].link_good),
        .active_out(any_act[gp])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic req;
    logic wr_hit;
    logic tick;
    logic [FB-1:0] word;
    logic [psi_pkg::EVT_BITS-1:0] set_evt;
    logic [psi_pkg::EVT_BITS-1:0] clr_evt;
    logic [psi_pkg::EVT_BITS-1:0] evt_new;
    psi_pkg::psi_port_t port_irq;
    logic interrupt_pin_mode;
    logic dup_mode;
    req = 1'b0;
    wr_hit = 1'b0;
    tick = 1'b0;
    word = '0;
    set_evt = '0;
    clr_evt = '0;
    evt_new = '0;
    port_irq = '0;
    interrupt_pin_mode = 1'b0;
    dup_mode = 1'b0;
    st_nxt = st_r;

    if (!rst_n_in) begin
      // Hardware reset: defaults and strap capture
      st_nxt = '0;
      st_nxt.serial_mode = !serial_indicator_select_n_in;
      st_nxt.lowcost_mode = !lowcost_serial_indicator_select_n_in;
      st_nxt.txerr_mode = !transmit_error_pin_select_n_in;
      st_nxt.ctrl = psi_pkg::CTRL_RESET;
      st_nxt.mask = psi_pkg::MASK_RESET;
      st_nxt.wait_n = 1'b0;
      st_nxt.pins.link_n = '1;
      st_nxt.pins.speed_n = '1;
      st_nxt.pins.speed_oe_n = '1;
      st_nxt.pins.xmt_n = '1;
      st_nxt.pins.rcv_n = '1;
    end else begin
      interrupt_pin_mode = st_r.ctrl[psi_pkg::CTRL_PORT_INTERRUPT_N_BIT];
      dup_mode = st_r.ctrl[psi_pkg::CTRL_DUPLEX_BIT] && !interrupt_pin_mode;

      // Bus slave: one wait cycle, then the answer
      req = avs_read_in || avs_write_in;
      st_nxt.wait_n = req && !st_r.wait_n;
      if (req && !st_r.wait_n) begin
        st_nxt.rdata = read_word(avs_address_in, st_r, link_now);
      end
      wr_hit = avs_write_in && st_r.wait_n;
      if (wr_hit) begin
        case (avs_address_in)
          psi_pkg::REG_CTRL: begin
            st_nxt.ctrl = avs_writedata_in[1:0];
          end
          psi_pkg::REG_EVENT: begin
            clr_evt = avs_writedata_in[psi_pkg::EVT_BITS-1:0];
          end
          psi_pkg::REG_MASK: begin
            st_nxt.mask = avs_writedata_in[psi_pkg::EVT_BITS-1:0];
          end
          default: begin
            clr_evt = '0;                 // Other writes ignored
          end
        endcase
      end

      // Events, set wins over a clear in the same cycle
      set_evt[psi_pkg::EVT_LINK_LSB +: NP] = link_now ^ st_r.link_prev;
      if (st_r.txerr_mode) begin
        set_evt[psi_pkg::EVT_TXERR_LSB +: NP] = transmit_error_in;
      end
      st_nxt.link_prev = link_now;
      evt_new = (st_r.evt & ~clr_evt) | set_evt;
      st_nxt.evt = evt_new;
      st_nxt.irq = |(evt_new & st_nxt.mask);
      for (int p = 0; p < NP; p++) begin
        port_irq[p] =
          (evt_new[psi_pkg::EVT_LINK_LSB + p] &
           st_nxt.mask[psi_pkg::EVT_LINK_LSB + p]) |
          (evt_new[psi_pkg::EVT_TXERR_LSB + p] &
           st_nxt.mask[psi_pkg::EVT_TXERR_LSB + p]);
      end

      // Serial frame word: per port {activity, duplex, speed, link}
      for (int p = 0; p < NP; p++) begin
        word[p * psi_pkg::FIELDS_PER_PORT + 0] = phy_in[p].link_good;
        word[p * psi_pkg::FIELDS_PER_PORT + 1] = phy_in[p].speed100;
        word[p * psi_pkg::FIELDS_PER_PORT + 2] = phy_in[p].full_duplex;
        word[p * psi_pkg::FIELDS_PER_PORT + 3] = any_act[p];
      end

      // Serial engine, runs in either serial mode
      if (st_r.serial_mode || st_r.lowcost_mode) begin
        tick = (st_r.div == DIV_LAST);
        st_nxt.div = tick ? '0 : st_r.div + DIV_ONE;
        if (tick) begin
          st_nxt.sclk = !st_r.sclk;
          if (st_r.sclk) begin
            // Falling edge of the serial clock moves to the next bit
            if (st_r.idx == IDX_W'(FB - 1)) begin
              st_nxt.idx = '0;
              st_nxt.frame = word;       // Snapshot for the next frame
              st_nxt.sdata = word[0];
            end else begin
              st_nxt.idx = st_r.idx + IDX_ONE;
              st_nxt.sdata = st_r.frame[st_r.idx + IDX_ONE];
            end
          end
        end
      end

      // Transmit error path towards the core
      st_nxt.txerr = st_r.txerr_mode ? transmit_error_in : '0;

      // Pin levels per port
      for (int p = 0; p < NP; p++) begin
        st_nxt.pins.link_n[p] = !phy_in[p].link_good;
        st_nxt.pins.speed_n[p] = !phy_in[p].speed100;
        st_nxt.pins.speed_oe_n[p] = st_r.txerr_mode;

        if (interrupt_pin_mode) begin
          st_nxt.pins.xmt_n[p] = !port_irq[p];
        end else if (dup_mode) begin
          st_nxt.pins.xmt_n[p] = !phy_in[p].full_duplex;
        end else begin
          st_nxt.pins.xmt_n[p] = !tx_act[p];
        end

        if (interrupt_pin_mode || dup_mode) begin
          st_nxt.pins.rcv_n[p] = !any_act[p];
        end else begin
          st_nxt.pins.rcv_n[p] = !rx_act[p];
        end
      end

      // Serial mode takes over the second port's pins
      if (st_r.serial_mode) begin
        st_nxt.pins.link_n[1] = (st_nxt.idx == '0);
        st_nxt.pins.xmt_n[1] = !st_nxt.sdata;
        st_nxt.pins.rcv_n[1] = st_nxt.sclk;
      end

      // Low-cost mode takes over the first and third receive pins
      if (st_r.lowcost_mode) begin
        st_nxt.pins.rcv_n[0] = st_nxt.sclk;
        st_nxt.pins.rcv_n[2] = !st_nxt.sdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_in) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign pins_out = st_r.pins;
  assign transmit_error_out = st_r.txerr;
  assign avs_readdata_out = st_r.rdata;
  assign avs_waitrequest_out = !st_r.wait_n;
  assign irq_out = st_r.irq;

endmodule

/* File: tb/psi_checker.sv */
// Purpose: Port assertions for the status indicator block
// Assumes: Bound into psi_indicator_top
// Notes: Port 3 carries no serial overrides; port 0 only its receive pin in low-cost mode
`timescale 1ns/1ps
module psi_checker #(
  parameter int ACT_HOLD_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Watched ports
  input wire psi_pkg::psi_phy_s [psi_pkg::NUM_PORTS-1:0] phy_in,
  input wire psi_pkg::psi_port_t transmit_error_in,
  input wire psi_pkg::psi_pins_s pins_out,
  input wire psi_pkg::psi_port_t transmit_error_out,
  input wire logic irq_out
);
  ////////////////////////////////////////////////////////////////////////
  // Cycles since last activity of port 3
  logic [31:0] idle_r;
  // Restart on activity, saturate otherwise
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || phy_in[3].rx_activity || phy_in[3].tx_activity) begin
      idle_r <= '0;
    end else if (idle_r != '1) begin
      idle_r <= idle_r + 32'h1;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////
  // Properties
  property p_link;
    rst_n_in |=> (pins_out.link_n[0] == !$past(phy_in[0].link_good));
  endproperty
  property p_speed;
    !pins_out.speed_oe_n[0] |=>
      (pins_out.speed_n[0] == !$past(phy_in[0].speed100));
  endproperty
  property p_oe;
    $past(rst_n_in, 2) && $past(rst_n_in) |-> $stable(pins_out.speed_oe_n);
  endproperty
  property p_te_on;
    $past(rst_n_in) && pins_out.speed_oe_n[0] && transmit_error_in[0]
      |=> transmit_error_out[0];
  endproperty
  property p_te_off;
    !pins_out.speed_oe_n[0] |=> !transmit_error_out[0];
  endproperty
  property p_rx_on;
    (phy_in[3].link_good && phy_in[3].rx_activity) ##1 phy_in[3].link_good
      |=> !pins_out.rcv_n[3];
  endproperty
  property p_rx_gate;
    !phy_in[3].link_good ##1 !phy_in[3].link_good |=> pins_out.rcv_n[3];
  endproperty
  property p_rx_hold;
    (phy_in[3].link_good && phy_in[3].rx_activity) ##1
      phy_in[3].link_good [*8] |=> !pins_out.rcv_n[3];
  endproperty
  property p_rx_max;
    idle_r > ACT_HOLD_CYCLES + 1 |-> pins_out.rcv_n[3];
  endproperty
  a_link: assert property (p_link) else $error("link pin wrong");
  a_speed: assert property (p_speed) else $error("speed pin wrong");
  a_oe: assert property (p_oe) else $error("pin direction moved");
  a_te_on: assert property (p_te_on) else $error("error not passed");
  a_te_off: assert property (p_te_off) else $error("error leaked");
  a_rx_on: assert property (p_rx_on) else $error("rx pulse missing");
  a_rx_gate: assert property (p_rx_gate) else $error("rx without link");
  a_rx_hold: assert property (p_rx_hold) else $error("rx pulse short");
  a_rx_max: assert property (p_rx_max) else $error("rx pulse long");
  // Main scenarios
  c_rx: cover property (phy_in[3].rx_activity && phy_in[3].link_good);
  c_te: cover property (pins_out.speed_oe_n[0] && transmit_error_out[0]);
  c_irq: cover property ($rose(irq_out));
endmodule

/* File: tb/psi_led_model.sv */
// Purpose: Far side model: LEDs, serial shift logic, error driver
// Assumes: Serial clock sampled on its rising edge
// Notes: Frame word is the last complete sixteen bits
`timescale 1ns/1ps
module psi_led_model (
  // Clock
  input wire logic ref_clk_in,
  // Pins of the block
  input wire psi_pkg::psi_pins_s pins_in,
  // Error levels the controller wants
  input wire psi_pkg::psi_port_t err_req_in,
  // Shared speed and error wire
  output psi_pkg::psi_port_t err_wire_out,
  // Captured frame and clock edge counts
  output logic [15:0] frame_out,
  output logic [15:0] lclk_cnt_out
);
  logic [15:0] sh_r; // Bits of the frame in progress
  logic [4:0] idx_r; // Next bit index
  logic sclk_r; // Last serial clock level
  logic lclk_r; // Last low-cost clock level
  // Wire level: block's level while it drives, else the controller
  always_comb begin
    for (int p = 0; p < psi_pkg::NUM_PORTS; p++) begin
      err_wire_out[p] = pins_in.speed_oe_n[p] ? err_req_in[p] :
        pins_in.speed_n[p];
    end
  end
  initial begin
    sh_r = '0;
    idx_r = '0;
    frame_out = '0;
    lclk_cnt_out = '0;
    sclk_r = 1'b1;
    lclk_r = 1'b1;
  end
  // Shift in serial data on each rising serial clock
  always @(posedge ref_clk_in) begin
    sclk_r <= pins_in.rcv_n[1];
    lclk_r <= pins_in.rcv_n[0];
    if (pins_in.rcv_n[0] && !lclk_r) begin
      lclk_cnt_out <= lclk_cnt_out + 16'h1;
    end
    if (pins_in.rcv_n[1] && !sclk_r) begin
      if (pins_in.link_n[1]) begin
        if (idx_r == 5'h10) begin
          frame_out <= sh_r;
        end
        sh_r <= {15'h0, !pins_in.xmt_n[1]};
        idx_r <= 5'h1;
      end else if (idx_r < 5'h10) begin
        sh_r[idx_r[3:0]] <= !pins_in.xmt_n[1];
        idx_r <= idx_r + 5'h1;
      end
    end
  end
endmodule

/* File: tb/psi_indicator_top_tb_top.sv */
// Purpose: Self-checking bench of the status indicator block
// Assumes: Pulse 20 cycles, half bit 2 cycles
// Notes: Bus tasks wait for waitrequest low
`timescale 1ns/1ps
module psi_indicator_top_tb_top;
  logic clk, rst_n, s_ser, s_lc, s_te, rd, wr, avs_wait, irq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  psi_pkg::psi_phy_s [psi_pkg::NUM_PORTS-1:0] phy;
  psi_pkg::psi_port_t te, te_out, err_req;
  psi_pkg::psi_pins_s pins;
  logic [15:0] frame, lclk_n;
  int n_mismatch, comparisons;
  always #50 clk = ~clk;
  psi_indicator_top #(.ACT_HOLD_CYCLES(20), .SER_DIV_CYCLES(2)) dut_u (
    .ref_clk_in(clk), .rst_n_in(rst_n),
    .serial_indicator_select_n_in(s_ser),
    .lowcost_serial_indicator_select_n_in(s_lc),
    .transmit_error_pin_select_n_in(s_te), .phy_in(phy),
    .transmit_error_in(te), .pins_out(pins),
    .transmit_error_out(te_out), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(avs_wait),
    .irq_out(irq));
  psi_led_model part_u (.ref_clk_in(clk), .pins_in(pins),
    .err_req_in(err_req), .err_wire_out(te), .frame_out(frame),
    .lclk_cnt_out(lclk_n));
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    i = 0;
    @(posedge clk);
    while (avs_wait !== 1'b0 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (i == 20) chk("bus answer", 32'h0, 32'h1);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask
  task automatic rst_to(input logic ser, input logic lc, input logic t);
    @(posedge clk);
    rst_n <= 1'b0;
    s_ser <= ser;
    s_lc <= lc;
    s_te <= t;
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
  endtask
  task automatic pulse(input int p, input logic t, input logic r);
    @(posedge clk);
    phy[p].tx_activity <= t;
    phy[p].rx_activity <= r;
    @(posedge clk);
    phy[p].tx_activity <= 1'b0;
    phy[p].rx_activity <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_pins();
    for (int p = 0; p < 4; p++) begin
      phy[p].link_good <= !p[0];
      phy[p].speed100 <= (p < 2);
    end
    cyc(3);
    chk("link_n", 32'ha, 32'(pins.link_n));
    chk("speed_n", 32'hc, 32'(pins.speed_n));
    chk("speed_oe_n", 32'h0, 32'(pins.speed_oe_n));
    rd_chk("status", psi_pkg::REG_STATUS, 32'h5, '1);
    rd_chk("unmapped", 4'h2, 32'h0, '1);
    rd_chk("mask", psi_pkg::REG_MASK, 32'h0, '1);
  endtask
  task automatic t_act();
    for (int p = 0; p < 4; p++) phy[p].link_good <= (p != 2);
    cyc(2);
    pulse(0, 1'b1, 1'b0);
    pulse(3, 1'b0, 1'b1);
    pulse(2, 1'b1, 1'b0);
    cyc(4);
    chk("xmt0", 32'h0, 32'(pins.xmt_n[0]));
    chk("rcv3", 32'h0, 32'(pins.rcv_n[3]));
    chk("xmt2", 32'h1, 32'(pins.xmt_n[2]));
    cyc(6);
    pulse(0, 1'b1, 1'b0);
    cyc(15);
    chk("xmt0 again", 32'h0, 32'(pins.xmt_n[0]));
    cyc(10);
    chk("xmt0 end", 32'h1, 32'(pins.xmt_n[0]));
    phy[2].link_good <= 1'b1;
  endtask
  task automatic t_port_interrupt_n();
    wr_reg(psi_pkg::REG_EVENT, 32'hff);
    wr_reg(psi_pkg::REG_CTRL, 32'h1);
    wr_reg(psi_pkg::REG_MASK, 32'h1);
    phy[1].link_good <= 1'b0;
    cyc(3);
    chk("irq masked", 32'h0, 32'(irq));
    phy[0].link_good <= 1'b0;
    cyc(3);
    chk("irq", 32'h1, 32'(irq));
    chk("xmt0 port_interrupt_n", 32'h0, 32'(pins.xmt_n[0]));
    rd_chk("event", psi_pkg::REG_EVENT, 32'h3, '1);
    pulse(3, 1'b1, 1'b0);
    cyc(2);
    chk("rcv3 combined", 32'h0, 32'(pins.rcv_n[3]));
    wr_reg(psi_pkg::REG_EVENT, 32'h3);
    cyc(2);
    chk("irq clear", 32'h0, 32'(irq));
    chk("xmt0 clear", 32'h1, 32'(pins.xmt_n[0]));
    phy[0].link_good <= 1'b1;
    phy[1].link_good <= 1'b1;
    for (int p = 0; p < 4; p++) phy[p].full_duplex <= (p == 1);
    wr_reg(psi_pkg::REG_CTRL, 32'h2);
    cyc(3);
    chk("duplex", 32'hd, 32'(pins.xmt_n));
    wr_reg(psi_pkg::REG_CTRL, 32'h0);
    wr_reg(psi_pkg::REG_EVENT, 32'hff);
    for (int p = 0; p < 4; p++) phy[p].full_duplex <= 1'b0;
  endtask
  task automatic t_modes();
    logic [15:0] lc0;
    err_req <= 4'h9;
    rst_to(1'b1, 1'b1, 1'b0);
    chk("oe_n txerr", 32'hf, 32'(pins.speed_oe_n));
    chk("te_out", 32'h9, 32'(te_out));
    rd_chk("txerr mode", psi_pkg::REG_STATUS, 32'h40, 32'h40);
    rd_chk("txerr event", psi_pkg::REG_EVENT, 32'h90, 32'hf0);
    rst_to(1'b1, 1'b1, 1'b1);
    chk("te_out off", 32'h0, 32'(te_out));
    rst_to(1'b0, 1'b1, 1'b1);
    s_ser <= 1'b1;
    cyc(300);
    rd_chk("serial mode", psi_pkg::REG_STATUS, 32'h10, 32'h30);
    chk("frame", 32'h1133, 32'(frame));
    rst_to(1'b1, 1'b0, 1'b1);
    chk("lc idle", 32'h0, 32'(pins.rcv_n[0]));
    lc0 = lclk_n;
    cyc(100);
    rd_chk("lowcost mode", psi_pkg::REG_STATUS, 32'h20, 32'h30);
    chk("lc clock", 32'h1, 32'((lclk_n - lc0) > 16'd20));
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {s_ser, s_lc, s_te} = 3'h7;
    {rd, wr, addr, wdata} = '0;
    phy = '0;
    err_req = '0;
    n_mismatch = 0;
    comparisons = 0;
    rst_to(1'b1, 1'b1, 1'b1);
    t_pins();
    t_act();
    t_port_interrupt_n();
    t_modes();
    test_done();
  end
endmodule
bind psi_indicator_top psi_checker #(.ACT_HOLD_CYCLES(ACT_HOLD_CYCLES))
  chk_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .phy_in(phy_in),
  .transmit_error_in(transmit_error_in), .pins_out(pins_out),
  .transmit_error_out(transmit_error_out), .irq_out(irq_out));
